// ===== mpos_host_model.sv
// Purpose: host processor on the power pins
// Assumes: pins are open drain with device pull-ups
// Notes: a released pin reads high
`timescale 1ns/100ps
module mpos_host_model (
  input wire logic READY,
  input wire logic INTERFACE_SUPPLY_EN,
  input wire logic PRESS,
  input wire logic HOLD_RESET,
  output logic POWER_ON_REQUEST_N,
  output logic RESET_IN_N,
  output logic MAY_COMMAND,
  output logic HOST_PIN_DRIVE
);
  // pins pulled low only while asked, else pulled up
  assign POWER_ON_REQUEST_N = !PRESS;
  assign RESET_IN_N = !HOLD_RESET;
  // commands wait for readiness
  assign MAY_COMMAND = READY;
  // digital lines driven only once the interface supply shows
  assign HOST_PIN_DRIVE = INTERFACE_SUPPLY_EN;
endmodule // mpos_host_model

// ===== mpos_pkg.sv
// Purpose: constants, register map and types of the power-on sequencer
// Assumes: 100 MHz CLK, classic Wishbone register access
// Notes: times kept in ns, cycle counts derived from them
package mpos_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned PULSE_MIN_NS = 10000;
  localparam int unsigned PULSE_MIN_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_HOLD_NS = 20000;
  localparam int unsigned RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CFG_STEP_NS = 1000;
  localparam int unsigned CFG_STEP_CYC = (CFG_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RTC_TICK_NS = 1000000;
  localparam int unsigned RTC_TICK_CYC = RTC_TICK_NS / CLK_PERIOD_NS;

  // ==========================================================
  // sizes
  localparam int unsigned PIN_GROUPS = 4;
  localparam int unsigned CNT_W = 16;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ALARM = 8'h08;
  localparam logic [7:0] REG_RTC_TIME = 8'h0c;
  localparam logic [7:0] REG_PAGE_PER = 8'h10;

  // ==========================================================
  // control and status bits
  localparam int unsigned CTRL_PS_EN = 0;
  localparam int unsigned CTRL_GREET_EN = 1;
  localparam int unsigned CTRL_AUTOBAUD = 2;
  localparam int unsigned CTRL_REGISTERED = 3;
  localparam int unsigned CTRL_CARD = 4;
  localparam int unsigned CTRL_SWITCH_OFF = 5;
  localparam int unsigned STAT_READY = 6;
  localparam int unsigned STAT_ALARM = 7;
  localparam int unsigned STAT_CFG_LSB = 8;
  localparam logic [15:0] PAGE_PER_RST = 16'h0080;

  // synchroniser lanes
  localparam int unsigned IN_PWR_N = 0;
  localparam int unsigned IN_RST_N = 1;
  localparam int unsigned IN_VALID = 2;
  localparam int unsigned IN_LOW = 3;
  localparam logic [3:0] IN_RST_VAL = 4'h3;

  // ==========================================================
  // sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_UNPOWERED = 6'h01,
    ST_OFF = 6'h02,
    ST_RESET = 6'h04,
    ST_CONFIG = 6'h08,
    ST_ON = 6'h10,
    ST_SPARE = 6'h20
  } mpos_state_e;

endpackage

// ===== mpos_top.sv
// Purpose: power-state and power-on sequencing of a cellular module
// Assumes: supply monitor gives level flags; pins are asynchronous
// Notes: registers on classic Wishbone, one cycle answer
`timescale 1ns/100ps
module mpos_top #(
  parameter int unsigned RTC_TICK_CYCLES = mpos_pkg::RTC_TICK_CYC
) (
  input wire logic CLK,
  input wire logic RESET_N,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // supply monitor and pins
  input wire logic SUPPLY_VALID,
  input wire logic SUPPLY_BELOW_LOW,
  input wire logic POWER_ON_REQUEST_N,
  input wire logic RESET_IN_N,
  input wire logic IDLE_REQ,
  output logic POWER_ON_PULLUP_EN,
  output logic RESET_PULLUP_EN,
  output logic RTC_BACKUP_SUPPLY_EN,
  output logic INTERFACE_SUPPLY_EN,
  output logic CORE_RESET_N,
  output logic [mpos_pkg::PIN_GROUPS-1:0] PIN_CFG_DONE,
  output logic [mpos_pkg::PIN_GROUPS-1:0] PIN_OE_N,
  output logic READY,
  output logic GREETING_SEND,
  output logic USB_ATTACH,
  output logic IDLE_LOW_POWER,
  output logic CLOCK_FAST_SEL,
  output logic PAGING_RX_EN
);
  import mpos_pkg::*;

  // ==========================================================
  // state record
  typedef struct packed {
    mpos_state_e state;
    // input capture and pulse timing
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [3:0] filt;
    logic armed;
    logic [CNT_W-1:0] pwr_cnt;
    logic [CNT_W-1:0] rst_cnt;
    logic [CNT_W-1:0] tcnt;
    logic [2:0] cfg_idx;
    logic [PIN_GROUPS-1:0] cfg_done;
    // time reference and alarm
    logic [31:0] rtc_pre;
    logic [31:0] rtc_time;
    logic [31:0] alarm_val;
    logic alarm_armed;
    logic alarm_flag;
    // software settings and one-cycle pulses
    logic ps_en;
    logic greet_en;
    logic autobaud;
    logic registered;
    logic card;
    logic [15:0] page_per;
    logic [15:0] page_cnt;
    logic page_pulse;
    logic idle;
    logic greet_pulse;
    logic attach_pulse;
    logic ack;
    logic [31:0] dat;
  } mpos_regs_s;

  mpos_regs_s r_reg;
  mpos_regs_s r_next;

  // saturating low-time counter for pulse qualification
  function automatic logic [CNT_W-1:0] low_count(input logic low, input logic [CNT_W-1:0] cnt);
    if (!low) begin
      return '0;
    end else if (cnt < CNT_W'(PULSE_MIN_CYC)) begin
      return cnt + CNT_W'(1);
    end
    return cnt;
  endfunction

  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ==========================================================
  // state decodes used by the supply and reset outputs, not by status
  // interface supply stands from reset hold to switch-off
  function automatic logic supply_on(input mpos_state_e st);
    return (st == ST_RESET) || (st == ST_CONFIG) || (st == ST_ON);
  endfunction

  // core runs only once the hold time has passed
  function automatic logic core_run(input mpos_state_e st);
    return (st == ST_CONFIG) || (st == ST_ON);
  endfunction

  // control word as software reads it back
  // switch-off bit is a strobe and always reads zero
  function automatic logic [31:0] ctrl_image(input mpos_regs_s r);
    return {26'h0, 1'b0, r.card, r.registered, r.autobaud, r.greet_en, r.ps_en};
  endfunction

  // status word: groups, alarm flag, ready, state one-hot
  function automatic logic [31:0] status_image(input mpos_regs_s r);
    return {20'h0, r.cfg_done, r.alarm_flag, r.state == ST_ON, 1'b0, r.state[4:0]};
  endfunction

  // ==========================================================
  // next-state logic
  // one process computes the whole record; pulses default low
  // so each lasts exactly one cycle, and every later block may
  // override an earlier one (supply loss last, set over clear)
  always_comb begin
    logic req;
    logic wr;
    logic pwr_evt;
    logic rst_evt;
    logic alarm_hit;
    logic tick;
    logic sw_off;
    logic [31:0] ctrl_w;
    req = 1'b0;
    wr = 1'b0;
    pwr_evt = 1'b0;
    rst_evt = 1'b0;
    alarm_hit = 1'b0;
    tick = 1'b0;
    sw_off = 1'b0;
    ctrl_w = '0;
    r_next = r_reg;
    r_next.greet_pulse = 1'b0;
    r_next.attach_pulse = 1'b0;
    r_next.page_pulse = 1'b0;

    // three-stage input capture, filtered when stages two and three agree
    r_next.sync1 = {SUPPLY_BELOW_LOW, SUPPLY_VALID, RESET_IN_N, POWER_ON_REQUEST_N};
    r_next.sync2 = r_reg.sync1;
    r_next.sync3 = r_reg.sync2;
    // a glitch shorter than two cycles never reaches filt
    // filt holds its value while the stages disagree
    for (int i = 0; i < 4; i++) begin
      if (r_reg.sync2[i] == r_reg.sync3[i]) begin
        r_next.filt[i] = r_reg.sync2[i];
      end
    end

    // low pulses on request and reset qualified by minimum length
    // counter saturates so a held-low pin fires only once
    // event fires on the cycle the count reaches the minimum
    r_next.pwr_cnt = low_count(!r_reg.filt[IN_PWR_N], r_reg.pwr_cnt);
    r_next.rst_cnt = low_count(!r_reg.filt[IN_RST_N], r_reg.rst_cnt);
    pwr_evt = (r_reg.pwr_cnt == CNT_W'(PULSE_MIN_CYC - 1)) && !r_reg.filt[IN_PWR_N];
    rst_evt = (r_reg.rst_cnt == CNT_W'(PULSE_MIN_CYC - 1)) && !r_reg.filt[IN_RST_N];

    // real-time clock runs on backup in every state
    // the prescaler never stops, so the time reference
    // survives switch-off
    if (r_reg.rtc_pre >= RTC_TICK_CYCLES - 1) begin
      r_next.rtc_pre = '0;
      r_next.rtc_time = r_reg.rtc_time + 32'h1;
      tick = 1'b1;
    end else begin
      r_next.rtc_pre = r_reg.rtc_pre + 32'h1;
    end
    alarm_hit = tick && r_reg.alarm_armed && (r_next.rtc_time == r_reg.alarm_val);
    if (alarm_hit) begin
      r_next.alarm_armed = 1'b0;
    end

    // wishbone slave, one-cycle answer, unmapped reads zero
    // ack high blocks a second take of one request
    // read data captured with ack and held until the next read
    // unmapped writes are dropped
    req = WB_CYC_I && WB_STB_I && !r_reg.ack;
    wr = req && WB_WE_I;
    r_next.ack = req;
    if (req && !WB_WE_I) begin
      if (WB_ADR_I == REG_CTRL) begin
        r_next.dat = ctrl_image(r_reg);
      end else if (WB_ADR_I == REG_STATUS) begin
        r_next.dat = status_image(r_reg);
      end else if (WB_ADR_I == REG_ALARM) begin
        r_next.dat = r_reg.alarm_val;
      end else if (WB_ADR_I == REG_RTC_TIME) begin
        r_next.dat = r_reg.rtc_time;
      end else if (WB_ADR_I == REG_PAGE_PER) begin
        r_next.dat = {16'h0, r_reg.page_per};
      end else begin
        r_next.dat = '0;
      end
    end
    if (wr) begin
      if (WB_ADR_I == REG_CTRL) begin
        // power saving command is this write
        ctrl_w = merge(ctrl_image(r_reg), WB_DAT_I, WB_SEL_I);
        r_next.ps_en = ctrl_w[CTRL_PS_EN];
        r_next.greet_en = ctrl_w[CTRL_GREET_EN];
        r_next.autobaud = ctrl_w[CTRL_AUTOBAUD];
        r_next.registered = ctrl_w[CTRL_REGISTERED];
        r_next.card = ctrl_w[CTRL_CARD];
        // strobe bits act only on the low byte lane
        sw_off = WB_SEL_I[0] && WB_DAT_I[CTRL_SWITCH_OFF];
      end else if (WB_ADR_I == REG_STATUS) begin
        // write one clears the alarm flag
        if (WB_SEL_I[0] && WB_DAT_I[STAT_ALARM]) begin
          r_next.alarm_flag = 1'b0;
        end
      end else if (WB_ADR_I == REG_ALARM) begin
        // alarm set command arms the compare
        r_next.alarm_val = merge(r_reg.alarm_val, WB_DAT_I, WB_SEL_I);
        r_next.alarm_armed = 1'b1;
      end else if (WB_ADR_I == REG_RTC_TIME) begin
        // software may set the time at any moment
        r_next.rtc_time = merge(r_reg.rtc_time, WB_DAT_I, WB_SEL_I);
      end else if (WB_ADR_I == REG_PAGE_PER) begin
        // period taken from the low half only
        r_next.page_per = 16'(merge({16'h0, r_reg.page_per}, WB_DAT_I, WB_SEL_I));
      end
    end
    // hardware set wins over software clear
    if (alarm_hit) begin
      r_next.alarm_flag = 1'b1;
    end

    // supply ramp start below threshold arms the not-powered switch-on
    if (r_reg.filt[IN_LOW]) begin
      r_next.armed = 1'b1;
    end

    // power sequencer
    // unpowered and off keep the timer and pin groups cleared,
    // so each switch-on starts its sequence from the reset state
    r_next.tcnt = r_reg.tcnt + CNT_W'(1);
    case (r_reg.state)
      ST_UNPOWERED: begin
        r_next.tcnt = '0;
        r_next.cfg_done = '0;
        r_next.cfg_idx = '0;
        // request input not looked at while supply is applied
        if (r_reg.filt[IN_VALID] && r_reg.armed) begin
          r_next.armed = 1'b0;
          r_next.state = ST_RESET;
          r_next.attach_pulse = r_reg.card;
        end
      end
      ST_OFF: begin
        r_next.tcnt = '0;
        r_next.cfg_done = '0;
        r_next.cfg_idx = '0;
        // a set alarm flag also counts as an expired alarm
        if (pwr_evt || rst_evt || alarm_hit || r_reg.alarm_flag) begin
          r_next.state = ST_RESET;
          r_next.attach_pulse = r_reg.card;
        end
      end
      ST_RESET: begin
        // hold time starts only once external reset is released
        if (!r_reg.filt[IN_RST_N]) begin
          r_next.tcnt = '0;
        end else if (r_reg.tcnt >= CNT_W'(RESET_HOLD_CYC - 1)) begin
          r_next.tcnt = '0;
          r_next.state = ST_CONFIG;
        end
      end
      ST_CONFIG: begin
        // one pin group leaves reset state per step
        if (r_reg.tcnt >= CNT_W'(CFG_STEP_CYC - 1)) begin
          r_next.tcnt = '0;
          r_next.cfg_done[r_reg.cfg_idx[1:0]] = 1'b1;
          r_next.cfg_idx = r_reg.cfg_idx + 3'h1;
          // last group sets ready and, with greeting on and autobaud off, the one-shot greeting
          if (r_reg.cfg_idx == 3'(PIN_GROUPS - 1)) begin
            r_next.state = ST_ON;
            r_next.greet_pulse = r_reg.greet_en && !r_reg.autobaud;
          end
        end
      end
      ST_ON: begin
        r_next.tcnt = '0;
        // switch-off strobe drops the interface supply at once
        if (sw_off) begin
          r_next.state = ST_OFF;
        end
      end
      default: begin
        r_next.state = ST_UNPOWERED;
      end
    endcase
    // supply loss overrides every transition made above
    if (!r_reg.filt[IN_VALID] && r_reg.state != ST_UNPOWERED) begin
      r_next.state = ST_UNPOWERED;
    end

    // paging timer counts clock ticks while registered and on
    // counter cleared outside, so a new registration restarts it
    if (r_reg.state == ST_ON && r_reg.registered) begin
      if (tick) begin
        if (r_reg.page_cnt >= r_reg.page_per - 16'h1) begin
          r_next.page_cnt = '0;
          r_next.page_pulse = 1'b1;
        end else begin
          r_next.page_cnt = r_reg.page_cnt + 16'h1;
        end
      end
    end else begin
      r_next.page_cnt = '0;
    end

    // low-power idle only with power saving on, woken for paging
    // the paging pulse keeps the core awake for that reception
    r_next.idle = r_reg.ps_en && IDLE_REQ && (r_reg.state == ST_ON) && !r_next.page_pulse;
  end

  // ==========================================================
  // state register
  // only constants in the reset branch; the filter starts at
  // the pins' idle level so no false edge follows reset
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      r_reg <= '0;
      r_reg.state <= ST_UNPOWERED;
      r_reg.sync1 <= IN_RST_VAL;
      r_reg.sync2 <= IN_RST_VAL;
      r_reg.sync3 <= IN_RST_VAL;
      r_reg.filt <= IN_RST_VAL;
      r_reg.armed <= 1'b1;
      r_reg.ps_en <= 1'b0;
      r_reg.autobaud <= 1'b1;
      r_reg.page_per <= PAGE_PER_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // outputs
  assign WB_ACK_O = r_reg.ack;
  assign WB_DAT_O = r_reg.dat;
  // pull-ups are permanent: released pins read high
  assign POWER_ON_PULLUP_EN = 1'b1;
  assign RESET_PULLUP_EN = 1'b1;
  assign RTC_BACKUP_SUPPLY_EN = r_reg.filt[IN_VALID];
  // supply and reset decoded from the state by supply_on and core_run
  assign INTERFACE_SUPPLY_EN = supply_on(r_reg.state);
  assign CORE_RESET_N = core_run(r_reg.state);
  assign PIN_CFG_DONE = r_reg.cfg_done;
  // each group drives only once configured and supplied
  // an undriven group floats rather than fights the host
  for (genvar g = 0; g < PIN_GROUPS; g++) begin : g_pin_oe
    assign PIN_OE_N[g] = !(r_reg.cfg_done[g] && INTERFACE_SUPPLY_EN);
  end
  // pulses and levels straight from the record
  assign READY = r_reg.state == ST_ON;
  assign GREETING_SEND = r_reg.greet_pulse;
  assign USB_ATTACH = r_reg.attach_pulse;
  assign IDLE_LOW_POWER = r_reg.idle;
  assign CLOCK_FAST_SEL = !r_reg.idle;
  assign PAGING_RX_EN = r_reg.page_pulse;

endmodule // mpos_top

// ===== mpos_top_checker.sv
// Purpose: port-level assertions of the power-on sequencer
// Assumes: one clock, synchronous active-low reset
// Notes: bound into mpos_top below the module
`timescale 1ns/100ps
module mpos_top_checker (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic SUPPLY_VALID,
  input wire logic IDLE_REQ,
  input wire logic POWER_ON_PULLUP_EN,
  input wire logic RESET_PULLUP_EN,
  input wire logic RTC_BACKUP_SUPPLY_EN,
  input wire logic INTERFACE_SUPPLY_EN,
  input wire logic CORE_RESET_N,
  input wire logic [mpos_pkg::PIN_GROUPS-1:0] PIN_CFG_DONE,
  input wire logic [mpos_pkg::PIN_GROUPS-1:0] PIN_OE_N,
  input wire logic READY,
  input wire logic GREETING_SEND,
  input wire logic USB_ATTACH,
  input wire logic IDLE_LOW_POWER,
  input wire logic CLOCK_FAST_SEL,
  input wire logic PAGING_RX_EN
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // ==========
  // supply, reset, pin, ready, greeting, idle and clock relations
  a_pull_ups: assert property (POWER_ON_PULLUP_EN && RESET_PULLUP_EN)
    else $error("pull-up off");
  a_backup_on: assert property (SUPPLY_VALID [*8] |-> RTC_BACKUP_SUPPLY_EN)
    else $error("backup supply off");
  a_backup_off: assert property (!SUPPLY_VALID [*8] |-> !RTC_BACKUP_SUPPLY_EN)
    else $error("backup supply on");
  a_no_supply: assert property (!SUPPLY_VALID [*8] |-> !INTERFACE_SUPPLY_EN)
    else $error("on without supply");
  a_pins_tristate: assert property (!INTERFACE_SUPPLY_EN |-> PIN_OE_N == '1)
    else $error("pin driven without supply");
  a_pins_follow: assert property (INTERFACE_SUPPLY_EN |-> PIN_OE_N == ~PIN_CFG_DONE)
    else $error("pin drive not by group");
  a_core_held: assert property (!INTERFACE_SUPPLY_EN |-> !CORE_RESET_N)
    else $error("core out of reset while off");
  a_reset_hold: assert property ($rose(INTERFACE_SUPPLY_EN) |-> !CORE_RESET_N [*8])
    else $error("core reset released early");
  a_cfg_order: assert property (PIN_CFG_DONE inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf})
    else $error("groups out of order");
  a_ready_cfg: assert property (READY |-> PIN_CFG_DONE == 4'hf && CORE_RESET_N)
    else $error("ready before config");
  a_greet_ready: assert property (GREETING_SEND |-> READY)
    else $error("greeting before ready");
  a_attach_start: assert property (USB_ATTACH |-> INTERFACE_SUPPLY_EN && !CORE_RESET_N)
    else $error("attach not at start");
  a_idle_cause: assert property ((!IDLE_REQ || !READY) |=> !IDLE_LOW_POWER)
    else $error("idle without cause");
  a_fast_clock: assert property (CLOCK_FAST_SEL == !IDLE_LOW_POWER)
    else $error("clock select wrong");
  // main scenarios
  c_ready: cover property ($rose(READY));
  c_greet: cover property (GREETING_SEND);
  c_idle: cover property (IDLE_LOW_POWER);
  c_page: cover property (PAGING_RX_EN);
endmodule // mpos_top_checker

bind mpos_top mpos_top_checker i_chk (.CLK(CLK), .RESET_N(RESET_N), .SUPPLY_VALID(SUPPLY_VALID),
  .IDLE_REQ(IDLE_REQ), .POWER_ON_PULLUP_EN(POWER_ON_PULLUP_EN), .RESET_PULLUP_EN(RESET_PULLUP_EN),
  .RTC_BACKUP_SUPPLY_EN(RTC_BACKUP_SUPPLY_EN), .INTERFACE_SUPPLY_EN(INTERFACE_SUPPLY_EN),
  .CORE_RESET_N(CORE_RESET_N), .PIN_CFG_DONE(PIN_CFG_DONE), .PIN_OE_N(PIN_OE_N), .READY(READY),
  .GREETING_SEND(GREETING_SEND), .USB_ATTACH(USB_ATTACH), .IDLE_LOW_POWER(IDLE_LOW_POWER),
  .CLOCK_FAST_SEL(CLOCK_FAST_SEL), .PAGING_RX_EN(PAGING_RX_EN));

// ===== test_module_power_on_sequencer.sv
// Purpose: self-checking bench of the power-on sequencer
// Assumes: bench is bus master, host model on the pins
// Notes: rtc tick shortened to 10 cycles
`timescale 1ns/100ps
module test_module_power_on_sequencer;
  import mpos_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] e;} mpos_row_s;
  logic clk, rst_n, cyc, stb, we, ack, sup, below, press, hold, idle;
  logic pwr_n, rin_n, rtc, isup, core_n, ready, greet, attach, idle_lp, fast, page, may_cmd;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [3:0] cfg, oe_n;
  int mismatches = 0, n_compared = 0, n_greet = 0, n_attach = 0, n_page = 0, cycles = 0;
  mpos_row_s rows [5] = '{'{REG_CTRL, 32'h4}, '{REG_STATUS, 32'h1}, '{REG_PAGE_PER, 32'h80},
    '{8'h14, 32'h0}, '{8'hfc, 32'h0}};
  mpos_top #(.RTC_TICK_CYCLES(10)) i_dut (.CLK(clk), .RESET_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .SUPPLY_VALID(sup), .SUPPLY_BELOW_LOW(below), .POWER_ON_REQUEST_N(pwr_n), .RESET_IN_N(rin_n),
    .IDLE_REQ(idle), .POWER_ON_PULLUP_EN(), .RESET_PULLUP_EN(), .RTC_BACKUP_SUPPLY_EN(rtc),
    .INTERFACE_SUPPLY_EN(isup), .CORE_RESET_N(core_n), .PIN_CFG_DONE(cfg), .PIN_OE_N(oe_n),
    .READY(ready), .GREETING_SEND(greet), .USB_ATTACH(attach), .IDLE_LOW_POWER(idle_lp),
    .CLOCK_FAST_SEL(fast), .PAGING_RX_EN(page));
  mpos_host_model i_host (.READY(ready), .INTERFACE_SUPPLY_EN(isup), .PRESS(press), .HOLD_RESET(hold),
    .POWER_ON_REQUEST_N(pwr_n), .RESET_IN_N(rin_n), .MAY_COMMAND(may_cmd), .HOST_PIN_DRIVE());
  // ==========
  // clock, timeout and pulse counters
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    n_greet <= n_greet + int'(greet);
    n_attach <= n_attach + int'(attach);
    n_page <= n_page + int'(page);
    if (cycles == 40000) begin
      mismatches++;
      conclude();
    end
  end
  // compare, bus cycle and bounded wait
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do @(posedge clk); while (ack !== 1'b1);
    r = rdat;
    {cyc, stb, we} <= 3'b000;
  endtask
  task automatic wait_for(input int sel, input logic v, input int lim);
    int n;
    logic s;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      s = (sel == 0) ? may_cmd : (sel == 1) ? isup : core_n;
      n++;
    end while (s !== v && n < lim);
    chk("wait", 32'(s), 32'(v));
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ==========
  // main sequence
  initial begin
    {cyc, stb, we, sup, press, hold, idle} = '0;
    below = 1'b1;
    rst_n = 1'b0;
    adr = '0;
    wdat = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // reset values, unmapped place ignores writes
    wb(1'b1, 8'h14, 32'h5a, q);
    foreach (rows[i]) begin
      wb(1'b0, rows[i].a, 32'h0, q);
      chk("reg", q, rows[i].e);
    end
    chk("oe", 32'(oe_n), 32'hf);
    chk("fast", 32'(fast), 32'h1);
    // ramp with reset held low and request low
    wb(1'b1, REG_CTRL, 32'h12, q);
    @(posedge clk);
    {sup, below, press, hold} <= 4'b1011;
    wait_for(1, 1'b1, 20);
    chk("rtc", 32'(rtc), 32'h1);
    repeat (2500) @(posedge clk);
    chk("core", 32'(core_n), 32'h0);
    {press, hold} <= 2'b00;
    wait_for(2, 1'b1, 2100);
    wait_for(0, 1'b1, 500);
    chk("oe", 32'(oe_n), 32'h0);
    @(posedge clk);
    #1;
    chk("greet", n_greet, 1);
    chk("attach", n_attach, 1);
    // paging with saving off, then saving on and off
    @(posedge clk);
    idle <= 1'b1;
    wb(1'b1, REG_PAGE_PER, 32'h2, q);
    wb(1'b1, REG_CTRL, 32'h1a, q);
    repeat (100) @(posedge clk);
    chk("idle", 32'(idle_lp), 32'h0);
    chk("page", 32'(n_page > 0), 32'h1);
    wb(1'b1, REG_CTRL, 32'h11, q);
    repeat (5) @(posedge clk);
    chk("fast", 32'(fast), 32'h0);
    wb(1'b1, REG_CTRL, 32'h10, q);
    repeat (3) @(posedge clk);
    chk("idle", 32'(idle_lp), 32'h0);
    // switch-off, short then long request or reset pulse
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, REG_CTRL, 32'h20, q);
      wait_for(1, 1'b0, 20);
      chk("oe", 32'(oe_n), 32'hf);
      chk("rtc", 32'(rtc), 32'h1);
      @(posedge clk);
      {press, hold} <= (k != 0) ? 2'b01 : 2'b10;
      repeat (500) @(posedge clk);
      {press, hold} <= 2'b00;
      repeat (600) @(posedge clk);
      chk("short", 32'(isup), 32'h0);
      {press, hold} <= (k != 0) ? 2'b01 : 2'b10;
      wait_for(1, 1'b1, 1100);
      @(posedge clk);
      {press, hold} <= 2'b00;
      wait_for(0, 1'b1, 2600);
    end
    // alarm wakes from power-off
    wb(1'b1, REG_CTRL, 32'h20, q);
    wait_for(1, 1'b0, 20);
    wb(1'b0, REG_RTC_TIME, 32'h0, q);
    wb(1'b1, REG_ALARM, q + 32'h3, q);
    wait_for(1, 1'b1, 200);
    wb(1'b0, REG_STATUS, 32'h0, q);
    chk("alarm", 32'(q[STAT_ALARM]), 32'h1);
    // supply loss, long request without supply
    @(posedge clk);
    {sup, below, press} <= 3'b011;
    wait_for(1, 1'b0, 20);
    chk("rtc", 32'(rtc), 32'h0);
    repeat (1100) @(posedge clk);
    chk("nosup", 32'(isup), 32'h0);
    conclude();
  end
endmodule // test_module_power_on_sequencer
